// *** lbs_params.svh ***
// offsets, field positions, reset values and timing counts of the logic block storage
`ifndef LBS_PARAMS_SVH
`define LBS_PARAMS_SVH
`define LBS_ADDR_STORE       4'h0
`define LBS_ADDR_DRIVE       4'h4
`define LBS_ADDR_STATUS      4'h8
`define LBS_F_LATCH          0
`define LBS_F_FALLING        4
`define LBS_F_ALWAYS_EN      8
`define LBS_F_WIPE_OFF       12
`define LBS_F_BYPASS_SEL     16
`define LBS_STORE_W          20
`define LBS_F_TRI_MODE       0
`define LBS_F_PAD_IN_INV     4
`define LBS_F_SKIP_DELAY     5
`define LBS_F_PAD_OUT_INV    6
`define LBS_F_PAD_DIS_INV    7
`define LBS_DRIVE_W          8
`define LBS_STORE_RESET      20'h0_0000
`define LBS_DRIVE_RESET      8'h00
`define LBS_DELAY_TAPS       1
`endif

// *** lbs_pkg.sv ***
// types shared by the logic block storage and driver design
package lbs_pkg;
    typedef logic [3:0]  lbs_addr_t;   // register port address
    typedef logic [31:0] lbs_word_t;   // register port data
    // whole state of the block, registered in one process
    typedef struct packed {
        logic [19:0] cfg_store;   // storage element configuration
        logic [7:0]  cfg_drive;   // longline and pad configuration
        logic [3:0]  q;           // storage element contents
        logic        pulse_prev;  // last sampled shared pulse level
        logic        pad_s1;      // pad synchroniser stage one
        logic        pad_s2;      // pad synchroniser stage two
        logic        pad_s3;      // pad synchroniser stage three
        logic        pad_filt;    // accepted pad level
        logic        pad_dly;     // one-tap delay stage
        logic        pad_data;    // conditioned pad level to fabric
        logic [3:0]  ll_out;      // longline driver values
        logic [3:0]  ll_oe;       // longline driver enables
        logic [3:0]  ll_keep;     // keeper levels
        logic        pad_o;       // pad output value
        logic        pad_oe;      // pad output enable
        logic [31:0] rdata;       // read data, one cycle
    } lbs_state_s;
endpackage : lbs_pkg

// *** lbs_logic_block.sv ***
// logic block storage elements, longline drivers and pad signal conditioning
`include "lbs_params.svh"
`timescale 1ns/1ns
`default_nettype none
module lbs_logic_block
    import lbs_pkg::*;
#(
    parameter int N_ELEM = 4   // storage elements and longline drivers
) (
    input  wire logic              I_CORE_CLK,              // 20 MHz core clock
    input  wire logic              I_RST_B,                 // async reset, active low
    input  wire logic [3:0]        I_ADDR,                  // register address
    input  wire logic [31:0]       I_WDATA,                 // register write data
    input  wire logic              I_WR,                    // write strobe
    input  wire logic              I_RD,                    // read strobe
    output logic      [31:0]       O_RDATA,                 // read data, cycle after strobe
    input  wire logic              I_STORAGE_PULSE,         // shared_storage_pulse
    input  wire logic              I_CLOCK_ENABLE,          // shared clock enable, high active
    input  wire logic              I_ASYNC_WIPE,            // async_wipe, high active
    input  wire logic              I_GLOBAL_CLEAR_NET,      // global_clear_net, high active
    input  wire logic [N_ELEM-1:0] I_LUT_OUT,               // lookup function outputs
    input  wire logic [N_ELEM-1:0] I_BYPASS_DATA_IN,        // bypass_data_in
    output logic      [N_ELEM-1:0] O_STORED,                // element contents
    input  wire logic [N_ELEM-1:0] I_DRIVER_IN,             // longline driver inputs
    input  wire logic              I_SHARED_BUFFER_DISABLE, // shared_buffer_disable
    input  wire logic [N_ELEM-1:0] I_LONGLINE_IN,           // resolved longline levels
    output logic      [N_ELEM-1:0] O_LONGLINE_OUT,          // longline driven values
    output logic      [N_ELEM-1:0] O_LONGLINE_OE,           // longline output enables
    output logic      [N_ELEM-1:0] O_LONGLINE_KEEP,         // weak keeper levels
    input  wire logic              I_PAD_IN,                // pad pin level, asynchronous
    output logic                   O_PAD_DATA,              // conditioned pad input to fabric
    input  wire logic              I_PAD_OUT,               // pad output value from fabric
    input  wire logic              I_PAD_DISABLE,           // pad output disable from fabric
    output logic                   O_PAD_O,                 // pad pin output value
    output logic                   O_PAD_OE                 // pad pin output enable
);

    lbs_state_s r_reg;    // registered state
    lbs_state_s r_next;   // next state

    logic [N_ELEM-1:0] latch_mode;   // 1 = level latch
    logic [N_ELEM-1:0] falling;      // 1 = falling edge or low level
    logic [N_ELEM-1:0] always_en;    // 1 = enable ignored
    logic [N_ELEM-1:0] wipe_off;     // 1 = wipe ignored
    logic [N_ELEM-1:0] bypass_sel;   // 1 = bypass data feeds element
    logic [N_ELEM-1:0] tri_mode;     // 1 = driver obeys shared disable
    logic              pulse_rise;   // shared pulse rising this cycle
    logic              pulse_fall;   // shared pulse falling this cycle
    logic              reconfig;     // storage configuration rewritten

    // configuration fields split out for readability
    always_comb begin
        latch_mode = r_reg.cfg_store[`LBS_F_LATCH +: N_ELEM];
        falling    = r_reg.cfg_store[`LBS_F_FALLING +: N_ELEM];
        always_en  = r_reg.cfg_store[`LBS_F_ALWAYS_EN +: N_ELEM];
        wipe_off   = r_reg.cfg_store[`LBS_F_WIPE_OFF +: N_ELEM];
        bypass_sel = r_reg.cfg_store[`LBS_F_BYPASS_SEL +: N_ELEM];
        tri_mode   = r_reg.cfg_drive[`LBS_F_TRI_MODE +: N_ELEM];
    end

    // next-state logic for the whole block
    always_comb begin
        r_next     = r_reg;
        reconfig   = 1'b0;
        pulse_rise = I_STORAGE_PULSE & ~r_reg.pulse_prev;
        pulse_fall = ~I_STORAGE_PULSE & r_reg.pulse_prev;

        // register port: reads answer only in the following cycle
        r_next.rdata = 32'h0000_0000;
        if (I_RD) begin
            unique case (I_ADDR)
                `LBS_ADDR_STORE: begin
                    r_next.rdata = {12'h000, r_reg.cfg_store};
                end
                `LBS_ADDR_DRIVE: begin
                    r_next.rdata = {24'h00_0000, r_reg.cfg_drive};
                end
                `LBS_ADDR_STATUS: begin
                    // live element, driver and pad state
                    r_next.rdata = {19'h0_0000, r_reg.pad_data, r_reg.ll_keep, r_reg.ll_oe, r_reg.q};
                end
                default: begin
                    r_next.rdata = 32'h0000_0000;   // unmapped reads as zero
                end
            endcase
        end
        if (I_WR) begin
            if (I_ADDR == `LBS_ADDR_STORE) begin
                r_next.cfg_store = I_WDATA[`LBS_STORE_W-1:0];
                reconfig         = 1'b1;   // new storage setup counts as reconfiguration
            end else if (I_ADDR == `LBS_ADDR_DRIVE) begin
                r_next.cfg_drive = I_WDATA[`LBS_DRIVE_W-1:0];
            end
        end

        // storage elements: shared pulse and enable, per element options
        r_next.pulse_prev = I_STORAGE_PULSE;
        for (int i = 0; i < N_ELEM; i++) begin
            // enable used as is, no inversion; forced on when unused
            if ((always_en[i] | I_CLOCK_ENABLE)) begin
                if (latch_mode[i]) begin
                    // transparent while the chosen level is present
                    if (falling[i] ? ~I_STORAGE_PULSE : I_STORAGE_PULSE) begin
                        r_next.q[i] = bypass_sel[i] ? I_BYPASS_DATA_IN[i] : I_LUT_OUT[i];
                    end
                end else if (falling[i] ? pulse_fall : pulse_rise) begin
                    r_next.q[i] = bypass_sel[i] ? I_BYPASS_DATA_IN[i] : I_LUT_OUT[i];
                end
            end
            // wipe beats any load; disabled elements ignore it
            if (I_ASYNC_WIPE && !wipe_off[i]) begin
                r_next.q[i] = 1'b0;
            end
            // global clear reaches every element regardless of options
            if (I_GLOBAL_CLEAR_NET || reconfig) begin
                r_next.q[i] = 1'b0;
            end
        end

        // longline drivers: always-on or gated by the shared disable
        for (int i = 0; i < N_ELEM; i++) begin
            r_next.ll_out[i] = I_DRIVER_IN[i];
            r_next.ll_oe[i]  = ~tri_mode[i] | ~I_SHARED_BUFFER_DISABLE;
        end
        // keeper follows the resolved line; an active driver sets that level
        r_next.ll_keep = I_LONGLINE_IN;

        // pad input: filtered sync, optional one tap, optional invert
        r_next.pad_s1 = I_PAD_IN;
        r_next.pad_s2 = r_reg.pad_s1;
        r_next.pad_s3 = r_reg.pad_s2;
        if (r_reg.pad_s2 == r_reg.pad_s3) begin
            r_next.pad_filt = r_reg.pad_s3;   // a change counts once stages agree
        end
        r_next.pad_dly  = r_reg.pad_filt;
        r_next.pad_data = (r_reg.cfg_drive[`LBS_F_SKIP_DELAY] ? r_reg.pad_filt : r_reg.pad_dly)
                          ^ r_reg.cfg_drive[`LBS_F_PAD_IN_INV];

        // pad output: per pad polarity of value and disable
        r_next.pad_o  = I_PAD_OUT ^ r_reg.cfg_drive[`LBS_F_PAD_OUT_INV];
        r_next.pad_oe = ~(I_PAD_DISABLE ^ r_reg.cfg_drive[`LBS_F_PAD_DIS_INV]);
    end

    // state register; power-up reset clears elements and configuration
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            r_reg           <= '0;
            r_reg.cfg_store <= `LBS_STORE_RESET;
            r_reg.cfg_drive <= `LBS_DRIVE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register; pad path has no user storage
    always_comb begin
        O_RDATA         = r_reg.rdata;
        O_STORED        = r_reg.q;
        O_LONGLINE_OUT  = r_reg.ll_out;
        O_LONGLINE_OE   = r_reg.ll_oe;
        O_LONGLINE_KEEP = r_reg.ll_keep;
        O_PAD_DATA      = r_reg.pad_data;
        O_PAD_O         = r_reg.pad_o;
        O_PAD_OE        = r_reg.pad_oe;
    end

endmodule // lbs_logic_block
`default_nettype wire

// *** lbs_monitor.sv ***
// port checker for the logic block storage and drivers
`timescale 1ns/1ns
`default_nettype none
module lbs_monitor #(parameter int N_ELEM = 4) (
    input wire logic              I_CORE_CLK,
    input wire logic              I_RST_B,
    input wire logic [3:0]        I_ADDR,
    input wire logic              I_WR,
    input wire logic              I_RD,
    input wire logic              I_GLOBAL_CLEAR_NET,
    input wire logic              I_SHARED_BUFFER_DISABLE,
    input wire logic [N_ELEM-1:0] I_DRIVER_IN,
    input wire logic [N_ELEM-1:0] I_LONGLINE_IN,
    input wire logic [31:0]       O_RDATA,
    input wire logic [N_ELEM-1:0] O_STORED,
    input wire logic [N_ELEM-1:0] O_LONGLINE_OUT,
    input wire logic [N_ELEM-1:0] O_LONGLINE_OE,
    input wire logic [N_ELEM-1:0] O_LONGLINE_KEEP
);
    // one domain, so clock and reset are given once
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);
    a_clear_empties: assert property (I_GLOBAL_CLEAR_NET |=> O_STORED == '0) else $error("clear missed");
    a_reconfig_empties: assert property (I_WR && I_ADDR == 4'h0 |=> O_STORED == '0) else $error("reconfig kept");
    // guards skip the first edge, where the registers still hold reset values
    a_keeper_tracks: assert property ($past(I_RST_B) |-> O_LONGLINE_KEEP == $past(I_LONGLINE_IN))
        else $error("keeper stale");
    a_buffer_passes: assert property ($past(I_RST_B) |-> O_LONGLINE_OUT == $past(I_DRIVER_IN))
        else $error("driver value wrong");
    a_enable_drives: assert property (!I_SHARED_BUFFER_DISABLE |=> &O_LONGLINE_OE) else $error("driver off");
    a_oe_holds: assert property ($past(I_RST_B) && $stable(I_SHARED_BUFFER_DISABLE) && !I_WR && !$past(I_WR)
        |=> $stable(O_LONGLINE_OE)) else $error("enable moved");
    a_read_idle: assert property (!I_RD |=> O_RDATA == 32'h0000_0000) else $error("read data lingers");
    a_status_mirror: assert property (I_RD && I_ADDR == 4'h8 |=> O_RDATA[3*N_ELEM-1:0] ==
        {$past(O_LONGLINE_KEEP), $past(O_LONGLINE_OE), $past(O_STORED)}) else $error("status wrong");
endmodule // lbs_monitor
bind lbs_logic_block lbs_monitor #(.N_ELEM(N_ELEM)) u_mon (.I_CORE_CLK, .I_RST_B, .I_ADDR, .I_WR, .I_RD,
    .I_GLOBAL_CLEAR_NET, .I_SHARED_BUFFER_DISABLE, .I_DRIVER_IN, .I_LONGLINE_IN, .O_RDATA, .O_STORED,
    .O_LONGLINE_OUT, .O_LONGLINE_OE, .O_LONGLINE_KEEP);
`default_nettype wire

// *** lbs_far_side.sv ***
// far side model: longline wires with keepers, and the pad pin
`timescale 1ns/1ns
`default_nettype none
module lbs_far_side (
    input  wire logic [3:0] i_oe,   // longline enables
    input  wire logic [3:0] i_val,  // longline values
    input  wire logic [3:0] i_keep, // keeper levels
    input  wire logic       i_high, // extra idle-high driver on
    input  wire logic       i_poe,  // pad buffer driving
    input  wire logic       i_po,   // pad buffer value
    input  wire logic       i_ext,  // outside source level
    output logic      [3:0] o_line, // resolved longlines
    output logic            o_pin   // resolved pad pin
);
    // any driver beats the weak keeper; the idle driver lifts floating lines
    assign o_line = (i_oe & i_val) | (~i_oe & ({4{i_high}} | i_keep));
    // outside source drives only while the pad buffer floats
    assign o_pin = i_poe ? i_po : i_ext;
endmodule // lbs_far_side
`default_nettype wire

// *** tb_logic_block_storage_and_drivers.sv ***
// self-checking bench for the logic block storage and drivers
`timescale 1ns/1ns
`default_nettype none
module tb_logic_block_storage_and_drivers;
    logic        I_CORE_CLK, I_RST_B, I_WR, I_RD, I_STORAGE_PULSE, I_CLOCK_ENABLE, I_ASYNC_WIPE;
    logic        I_GLOBAL_CLEAR_NET, I_SHARED_BUFFER_DISABLE, I_PAD_IN, O_PAD_DATA, I_PAD_OUT;
    logic        I_PAD_DISABLE, O_PAD_O, O_PAD_OE, high, ext;
    logic [3:0]  I_ADDR, I_LUT_OUT, I_BYPASS_DATA_IN, O_STORED, I_DRIVER_IN, I_LONGLINE_IN;
    logic [3:0]  O_LONGLINE_OUT, O_LONGLINE_OE, O_LONGLINE_KEEP;
    logic [31:0] I_WDATA, O_RDATA, v;
    int          fails = 0;
    int          comparisons = 0;
    lbs_logic_block dut (.*);
    lbs_far_side u_far (.i_oe(O_LONGLINE_OE), .i_val(O_LONGLINE_OUT), .i_keep(O_LONGLINE_KEEP), .i_high(high),
                        .i_poe(O_PAD_OE), .i_po(O_PAD_O), .i_ext(ext), .o_line(I_LONGLINE_IN), .o_pin(I_PAD_IN));
    initial begin
        I_CORE_CLK = 1'b0;
        forever #25 I_CORE_CLK = ~I_CORE_CLK;
    end
    task automatic st(input int n);
        repeat (n) @(posedge I_CORE_CLK);
    endtask
    // look only once the edge's updates have landed
    task automatic see(input int n);
        st(n);
        #10;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        st(1);
        {I_WR, I_ADDR, I_WDATA} <= {1'b1, a, d};
        st(1);
        I_WR <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        st(1);
        {I_RD, I_ADDR} <= {1'b1, a};
        st(1);
        I_RD <= 1'b0;
        #10;
        d = O_RDATA;
    endtask
    // cl is {wipe, global clear}; three edges cover detection and register latency
    task automatic sto(input logic ce, p, input logic [1:0] cl, input logic [3:0] lut, byp, exp);
        st(1);
        {I_CLOCK_ENABLE, I_STORAGE_PULSE, I_ASYNC_WIPE, I_GLOBAL_CLEAR_NET, I_LUT_OUT, I_BYPASS_DATA_IN} <=
            {ce, p, cl, lut, byp};
        see(3);
        chk("stored", O_STORED, exp);
    endtask
    task automatic ll(input logic dis, hi, input logic [3:0] din, oe, line);
        st(1);
        {I_SHARED_BUFFER_DISABLE, high, I_DRIVER_IN} <= {dis, hi, din};
        see(3);
        chk("oe", O_LONGLINE_OE, oe);
        chk("line", I_LONGLINE_IN, line);
    endtask
    task automatic pout(input logic o, d, input logic [1:0] exp);
        st(1);
        {I_PAD_OUT, I_PAD_DISABLE} <= {o, d};
        see(2);
        chk("pad out", {O_PAD_O, O_PAD_OE}, exp);
    endtask
    task automatic regs();
        rd(4'h0, v);
        chk("store cfg", v, 32'h0000_0000);
        wr(4'h4, 32'h0000_00A5);
        rd(4'h4, v);
        chk("drive cfg", v, 32'h0000_00A5);
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'h8, v);
        chk("status", v, 32'h0000_00F0);
        rd(4'hC, v);
        chk("unmapped", v, 32'h0000_0000);
    endtask
    task automatic storage_modes();
        wr(4'h0, 32'h0000_0000);
        sto(1'b1, 1'b1, 2'h0, 4'hA, 4'h0, 4'hA);
        sto(1'b1, 1'b0, 2'h0, 4'h5, 4'h0, 4'hA);
        sto(1'b0, 1'b1, 2'h0, 4'h5, 4'h0, 4'hA);
        wr(4'h0, 32'h000F_0FF0);
        sto(1'b0, 1'b0, 2'h0, 4'hA, 4'h5, 4'h5);
        sto(1'b0, 1'b1, 2'h0, 4'hA, 4'h9, 4'h5);
        wr(4'h0, 32'h0000_000F);
        sto(1'b1, 1'b0, 2'h0, 4'h3, 4'h0, 4'h0);
        sto(1'b1, 1'b1, 2'h0, 4'hC, 4'h0, 4'hC);
        sto(1'b0, 1'b1, 2'h0, 4'h6, 4'h0, 4'hC);
        sto(1'b1, 1'b0, 2'h0, 4'h6, 4'h0, 4'hC);
        wr(4'h0, 32'h0000_3000);
        sto(1'b1, 1'b1, 2'h0, 4'hF, 4'h0, 4'hF);
        sto(1'b1, 1'b1, 2'h2, 4'hF, 4'h0, 4'h3);
        sto(1'b1, 1'b1, 2'h1, 4'hF, 4'h0, 4'h0);
    endtask
    task automatic lines_and_pads();
        wr(4'h4, 32'h0000_0003);
        ll(1'b0, 1'b0, 4'h6, 4'hF, 4'h6);
        ll(1'b1, 1'b0, 4'h9, 4'hC, 4'hA);
        ll(1'b1, 1'b1, 4'h9, 4'hC, 4'hB);
        wr(4'h4, 32'h0000_0000);
        pout(1'b1, 1'b1, 2'h2);
        see(8);
        st(1);
        ext <= 1'b1;
        see(5);
        chk("pad in held", O_PAD_DATA, 1'b0);
        see(1);
        chk("pad in", O_PAD_DATA, 1'b1);
        wr(4'h4, 32'h0000_0030);
        see(8);
        chk("pad inverted", O_PAD_DATA, 1'b0);
        st(1);
        ext <= 1'b0;
        see(4);
        chk("pad skip held", O_PAD_DATA, 1'b0);
        see(1);
        chk("pad skip", O_PAD_DATA, 1'b1);
        pout(1'b1, 1'b0, 2'h3);
        wr(4'h4, 32'h0000_00C0);
        pout(1'b1, 1'b0, 2'h0);
        pout(1'b0, 1'b1, 2'h3);
        // open drain: data held low, disable follows the user signal
        wr(4'h4, 32'h0000_0000);
        pout(1'b0, 1'b1, 2'h0);
        pout(1'b0, 1'b0, 2'h1);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {I_RST_B, I_WR, I_RD, I_STORAGE_PULSE, I_CLOCK_ENABLE, I_ASYNC_WIPE, I_GLOBAL_CLEAR_NET} = '0;
        {I_SHARED_BUFFER_DISABLE, I_PAD_OUT, I_PAD_DISABLE, high, ext} = 5'h04;
        {I_ADDR, I_LUT_OUT, I_BYPASS_DATA_IN, I_DRIVER_IN, I_WDATA} = '0;
        st(2);
        I_RST_B <= 1'b1;
        regs();
        storage_modes();
        lines_and_pads();
        print_verdict();
    end
    // hang guard, far beyond the roughly 140 cycles the run needs
    initial begin
        #1_000_000;
        fails++;
        print_verdict();
    end
endmodule // tb_logic_block_storage_and_drivers
`default_nettype wire
